// File: design/cvt_map.svh
`ifndef CVT_MAP_SVH
`define CVT_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CVT_PRE_OFS 4'h0
`define CVT_ACQ_OFS 4'h1
`define CVT_GRD_OFS 4'h2
`define CVT_CTL_OFS 4'h3
`define CVT_STAT_OFS 4'h4
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CVT_GRD_BOE_BIT 7
`define CVT_GRD_AOE_BIT 6
`define CVT_GRD_POL_BIT 5
`define CVT_CTL_ON_BIT 0
`define CVT_CTL_RC_BIT 1
`define CVT_CTL_START_BIT 2
`define CVT_REG_RESET 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CVT_INSTR_DIV 4
`endif

// File: design/cvt_pkg.sv
package cvt_pkg;
	typedef enum logic [1:0] {
		CVT_IDLE,
		CVT_PRE,
		CVT_ACQ,
		CVT_CONV
	} cvt_phase_type;
endpackage : cvt_pkg

// File: design/cvt_tick.sv
`timescale 1ns/10ps
// ----------------------------------------
// tick source for the phase timers
// ----------------------------------------
module cvt_tick #(
	parameter int DIV = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic sync_clr,
	input wire logic rc_sel,
	input wire logic rc_tick_in,
	// tick
	output logic tick
);
	logic [3:0] div_q;
	logic div_tick;

	// instruction cycle divider
	always_ff @(posedge clk) begin
		if (rst || sync_clr) begin
			div_q <= 4'h0;
		end else if (ce) begin
			if (div_q == 4'(DIV - 1)) begin
				div_q <= 4'h0;
			end else begin
				div_q <= div_q + 4'h1;
			end
		end
	end

	assign div_tick = ce && (div_q == 4'(DIV - 1));
	// select internal rc tick or instruction tick
	assign tick = rc_sel ? (ce && rc_tick_in) : div_tick;
endmodule : cvt_tick

// File: design/cvt_timing.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "cvt_map.svh"
module cvt_timing #(
	parameter int CW = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// converter side
	input wire logic rc_tick,
	input wire logic conv_done,
	output cvt_pkg::cvt_phase_type phase,
	output logic conv_start,
	// guard pins
	input wire logic guard_a_dir_out,
	input wire logic guard_b_dir_out,
	output logic guard_a_pin_o,
	output logic guard_a_pin_oe,
	output logic guard_b_pin_o,
	output logic guard_b_pin_oe
);
	import cvt_pkg::*;

	logic [CW-1:0] precharge_count_q;
	logic [CW-1:0] acquisition_count_q;
	logic guard_b_output_enable_q;
	logic guard_a_output_enable_q;
	logic guard_start_polarity_q;
	logic converter_on_q;
	logic internal_rc_conversion_clock_q;
	logic start_req;
	cvt_phase_type phase_q;
	cvt_phase_type phase_d;
	logic [CW-1:0] cnt_q;
	logic tick;
	logic phase_enter;
	logic [7:0] rdata_q;
	logic ga_q;
	logic gb_q;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// writable fields, high bits dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			precharge_count_q <= '0;
			acquisition_count_q <= '0;
			guard_b_output_enable_q <= 1'b0;
			guard_a_output_enable_q <= 1'b0;
			guard_start_polarity_q <= 1'b0;
			converter_on_q <= 1'b0;
			internal_rc_conversion_clock_q <= 1'b0;
		end else if (ce && wr) begin
			unique case (addr)
				`CVT_PRE_OFS: precharge_count_q <= wdata[CW-1:0];
				`CVT_ACQ_OFS: acquisition_count_q <= wdata[CW-1:0];
				`CVT_GRD_OFS: begin
					guard_b_output_enable_q <= wdata[`CVT_GRD_BOE_BIT];
					guard_a_output_enable_q <= wdata[`CVT_GRD_AOE_BIT];
					guard_start_polarity_q <= wdata[`CVT_GRD_POL_BIT];
				end
				`CVT_CTL_OFS: begin
					converter_on_q <= wdata[`CVT_CTL_ON_BIT];
					internal_rc_conversion_clock_q <= wdata[`CVT_CTL_RC_BIT];
				end
				default: ;
			endcase
		end
	end

	// start strobe from control write
	assign start_req = ce && wr && (addr == `CVT_CTL_OFS) && wdata[`CVT_CTL_START_BIT]
		&& wdata[`CVT_CTL_ON_BIT];

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	// read data one cycle after strobe, zero in unused bits
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= `CVT_REG_RESET;
		end else if (ce) begin
			rdata_q <= 8'h00;
			if (rd) begin
				unique case (addr)
					`CVT_PRE_OFS: rdata_q <= {1'b0, precharge_count_q};
					`CVT_ACQ_OFS: rdata_q <= {1'b0, acquisition_count_q};
					`CVT_GRD_OFS: rdata_q <= {guard_b_output_enable_q,
						guard_a_output_enable_q, guard_start_polarity_q, 5'h00};
					`CVT_CTL_OFS: rdata_q <= {6'h00, internal_rc_conversion_clock_q,
						converter_on_q};
					`CVT_STAT_OFS: rdata_q <= {6'h00, phase_q};
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end
	assign rdata = rdata_q;

	// ----------------------------------------
	// phase timing
	// ----------------------------------------
	cvt_tick #(
		.DIV(`CVT_INSTR_DIV)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.sync_clr(phase_enter),
		.rc_sel(internal_rc_conversion_clock_q),
		.rc_tick_in(rc_tick),
		.tick(tick)
	);

	// next phase
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			CVT_IDLE: begin
				if (start_req) begin
					if (precharge_count_q != '0) begin
						phase_d = CVT_PRE;
					end else if (acquisition_count_q != '0) begin
						phase_d = CVT_ACQ;
					end else begin
						phase_d = CVT_CONV;
					end
				end
			end
			CVT_PRE: begin
				if (tick && cnt_q == CW'(1)) begin
					phase_d = (acquisition_count_q != '0) ? CVT_ACQ : CVT_CONV;
				end
			end
			CVT_ACQ: begin
				if (tick && cnt_q == CW'(1)) begin
					phase_d = CVT_CONV;
				end
			end
			CVT_CONV: begin
				if (conv_done) begin
					phase_d = CVT_IDLE;
				end
			end
		endcase
		// converter off ends a running sequence; idle still takes a start that sets on
		if (!converter_on_q && phase_q != CVT_IDLE) begin
			phase_d = CVT_IDLE;
		end
	end

	assign phase_enter = ce && (phase_d != phase_q);

	// phase register and remaining count
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q <= CVT_IDLE;
			cnt_q <= '0;
		end else if (ce) begin
			phase_q <= phase_d;
			if (phase_d != phase_q) begin
				cnt_q <= (phase_d == CVT_PRE) ? precharge_count_q : acquisition_count_q;
			end else if (tick && cnt_q != '0) begin
				cnt_q <= cnt_q - CW'(1);
			end
		end
	end

	assign phase = phase_q;
	assign conv_start = ce && phase_enter && (phase_d == CVT_CONV);

	// ----------------------------------------
	// guard ring drive
	// ----------------------------------------
	// start level from polarity, guard a flips at acquisition
	always_ff @(posedge clk) begin
		if (rst) begin
			ga_q <= 1'b0;
			gb_q <= 1'b0;
		end else if (ce) begin
			if (phase_d == CVT_PRE || phase_d == CVT_IDLE) begin
				ga_q <= guard_start_polarity_q;
				gb_q <= guard_start_polarity_q;
			end else if (phase_d == CVT_ACQ && phase_q != CVT_ACQ) begin
				ga_q <= ~ga_q;
			end
		end
	end

	assign guard_a_pin_o = ga_q;
	assign guard_b_pin_o = gb_q;
	assign guard_a_pin_oe = converter_on_q && guard_a_output_enable_q
		&& guard_a_dir_out;
	assign guard_b_pin_oe = converter_on_q && guard_b_output_enable_q
		&& guard_b_dir_out;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence acq_entry_s;
		phase_q != CVT_ACQ ##1 phase_q == CVT_ACQ;
	endsequence

	reset_regs_a: assert property (@(posedge clk) rst |=> precharge_count_q == '0 &&
		acquisition_count_q == '0 && !guard_start_polarity_q)
		else $error("registers not cleared by reset");
	zero_pre_skip_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_IDLE && phase_d != CVT_IDLE && precharge_count_q == '0
		|=> phase_q != CVT_PRE)
		else $error("pre-charge entered with zero count");
	zero_acq_skip_a: assert property (@(posedge clk) disable iff (rst)
		acquisition_count_q == '0 && $stable(acquisition_count_q) |-> phase_d != CVT_ACQ
		|| phase_q == CVT_ACQ)
		else $error("acquisition entered with zero count");
	phase_order_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_PRE && ce && phase_d != CVT_PRE && converter_on_q
		|-> phase_d inside {CVT_ACQ, CVT_CONV})
		else $error("pre-charge left to wrong phase");
	acq_order_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_ACQ && ce && phase_d != CVT_ACQ && converter_on_q |-> phase_d == CVT_CONV)
		else $error("acquisition not followed by conversion");
	pre_length_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_PRE && cnt_q != '0 && !tick && ce && converter_on_q
		|=> phase_q == CVT_PRE)
		else $error("pre-charge ended early");
	unused_read_a: assert property (@(posedge clk) disable iff (rst)
		rd && ce && (addr == `CVT_PRE_OFS || addr == `CVT_ACQ_OFS) |=> !rdata[7])
		else $error("unimplemented bit read as one");
	guard_flip_a: assert property (@(posedge clk) disable iff (rst || !ce)
		acq_entry_s |-> ga_q == !guard_start_polarity_q || !$stable(guard_start_polarity_q))
		else $error("guard a did not flip at acquisition");
	guard_off_a: assert property (@(posedge clk) disable iff (rst)
		!converter_on_q |-> !guard_a_pin_oe && !guard_b_pin_oe)
		else $error("guard driven while converter off");
	idle_on_a: assert property (@(posedge clk) disable iff (rst)
		!converter_on_q && !start_req && ce |=> phase_q == CVT_IDLE)
		else $error("sequence runs with converter off");

	// ----------------------------------------
	// further checks
	// ----------------------------------------
	// instruction ticks at least four cycles apart
	sequence instr_quiet_s;
		(!tick || internal_rc_conversion_clock_q) [*3];
	endsequence
	// tick source
	instr_tick_a: assert property (@(posedge clk) disable iff (rst)
		!internal_rc_conversion_clock_q && tick |=> instr_quiet_s)
		else $error("instruction tick closer than four cycles");
	rc_tick_a: assert property (@(posedge clk) disable iff (rst)
		internal_rc_conversion_clock_q |-> tick == (ce && rc_tick))
		else $error("timers not stepped by rc ticks");
	// sequencing
	acq_length_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_ACQ && cnt_q != '0 && !tick && ce && converter_on_q
		|=> phase_q == CVT_ACQ)
		else $error("acquisition ended early");
	conv_start_a: assert property (@(posedge clk) disable iff (rst)
		conv_start |=> phase_q == CVT_CONV)
		else $error("conversion start without conversion phase");
	freeze_state_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(phase_q) && $stable(cnt_q) && $stable(ga_q) && $stable(gb_q))
		else $error("state moved while clock enable low");
	// register port
	acq_write_a: assert property (@(posedge clk) disable iff (rst)
		ce && wr && addr == `CVT_ACQ_OFS |=> acquisition_count_q == $past(wdata[CW-1:0]))
		else $error("acquisition count not taken from low seven bits");
	unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
		ce && rd && addr > `CVT_STAT_OFS |=> rdata == 8'h00)
		else $error("unmapped address read as nonzero");
	guard_low_read_a: assert property (@(posedge clk) disable iff (rst)
		ce && rd && addr == `CVT_GRD_OFS |=> rdata[4:0] == 5'h00)
		else $error("unused guard bits read as nonzero");
	// guard drive
	guard_start_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_PRE && $past(ce) |-> ga_q == $past(guard_start_polarity_q)
		&& gb_q == $past(guard_start_polarity_q))
		else $error("guard start level differs from polarity bit");
	guard_b_hold_a: assert property (@(posedge clk) disable iff (rst)
		phase_q == CVT_ACQ |=> $stable(gb_q) || phase_q != CVT_ACQ)
		else $error("guard b moved during acquisition");
endmodule : cvt_timing

// File: tb/cvd_precharge_acq_timing_test.sv
`timescale 1ns/10ps
// ----------------------------------------
// bench for the phase timer block
// ----------------------------------------
module cvd_precharge_acq_timing_test;
	import cvt_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, ce = 1, rc_on = 0, dir_a = 1, dir_b = 1;
	logic [3:0] addr = 0;
	logic [7:0] wdata = 0, rdata;
	logic rc_tick, conv_done, conv_start, ao, aoe, bo, boe, a_pin, b_pin;
	cvt_phase_type phase;
	int n_fail = 0, comparisons = 0;
	logic [3:0] ra[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5};
	logic [7:0] re[5] = '{8'h7f, 8'h7f, 8'he0, 8'h00, 8'h00};

	cvt_timing dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .rc_tick(rc_tick), .conv_done(conv_done), .phase(phase),
		.conv_start(conv_start), .guard_a_dir_out(dir_a), .guard_b_dir_out(dir_b),
		.guard_a_pin_o(ao), .guard_a_pin_oe(aoe), .guard_b_pin_o(bo), .guard_b_pin_oe(boe));
	cvt_far_model far (.clk(clk), .conv_start(conv_start), .conv_done(conv_done),
		.rc_run(rc_on), .rc_tick(rc_tick), .a_o(ao), .a_oe(aoe), .b_o(bo), .b_oe(boe),
		.a_pin(a_pin), .b_pin(b_pin));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		chk("rdata", {8'h0, e}, {8'h0, rdata});
	endtask : rd_chk
	// one full sequence, counting cycles in pre-charge and acquisition
	task automatic run_seq(input logic [6:0] np, na, input logic rc, pol, input int tp, ta);
		int cp, ca, t;
		logic bad;
		cp = 0;
		ca = 0;
		bad = 0;
		rc_on <= rc;
		wr_reg(4'h0, {1'b0, np});
		wr_reg(4'h1, {1'b0, na});
		wr_reg(4'h2, {2'b11, pol, 5'h00});
		wr_reg(4'h3, {5'h00, 1'b1, rc, 1'b1});
		for (t = 0; t < 2000 && !(phase === CVT_CONV); t++) begin
			@(negedge clk);
			if (phase === CVT_PRE) begin
				cp++;
				bad |= (ca != 0) | (a_pin !== pol) | (b_pin !== pol);
			end
			if (phase === CVT_ACQ) begin
				ca++;
				bad |= (a_pin !== !pol) | (b_pin !== pol);
			end
		end
		chk("pre_cycles", tp[15:0], cp[15:0]);
		chk("acq_cycles", ta[15:0], ca[15:0]);
		chk("guard_levels", 16'h0000, {15'h0, bad});
		for (t = 0; t < 50 && !(phase === CVT_IDLE); t++)
			@(negedge clk);
		chk("phase_end", 16'h0000, {14'h0, phase});
	endtask : run_seq
	task automatic report_and_stop;
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// clock, watchdog, main sequence
	// ----------------------------------------
	initial forever #10 clk = ~clk;
	initial begin
		#400000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		int t;
		repeat (6) @(posedge clk);
		rst <= 0;
		foreach (ra[i]) rd_chk(ra[i], 8'h00);
		foreach (ra[i]) begin
			wr_reg(ra[i], 8'hff);
			rd_chk(ra[i], re[i]);
		end
		run_seq(7'h01, 7'h01, 1'b0, 1'b1, 4, 4);
		run_seq(7'h00, 7'h02, 1'b0, 1'b0, 0, 8);
		run_seq(7'h03, 7'h00, 1'b0, 1'b1, 12, 0);
		run_seq(7'h7f, 7'h7f, 1'b0, 1'b0, 508, 508);
		run_seq(7'h05, 7'h03, 1'b1, 1'b0, 5, 3);
		// enable needs direction bit; converter off drops drive
		@(posedge clk);
		dir_a <= 0;
		@(negedge clk);
		chk("oe_dir", 16'h0001, {14'h0, aoe, boe});
		wr_reg(4'h3, 8'h00);
		@(negedge clk);
		chk("oe_off", 16'h0000, {14'h0, aoe, boe});
		// clock enable low freezes the pre-charge timer
		wr_reg(4'h1, 8'h00);
		wr_reg(4'h0, 8'h02);
		wr_reg(4'h3, 8'h05);
		ce <= 0;
		repeat (10) @(posedge clk);
		ce <= 1;
		@(negedge clk);
		chk("ce_freeze", {14'h0, CVT_PRE}, {14'h0, phase});
		for (t = 0; t < 100 && phase === CVT_PRE; t++)
			@(negedge clk);
		chk("ce_pre_rest", 16'h0008, t[15:0]);
		for (t = 0; t < 50 && !(phase === CVT_IDLE); t++)
			@(negedge clk);
		// reset in mid-run clears everything
		wr_reg(4'h2, 8'he0);
		wr_reg(4'h0, 8'h7f);
		wr_reg(4'h3, 8'h05);
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk("rst_pins", 16'h0000, {12'h0, ao, aoe, bo, boe});
		foreach (ra[i]) rd_chk(ra[i], 8'h00);
		report_and_stop();
	end
endmodule : cvd_precharge_acq_timing_test

// File: tb/cvt_far_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// converter and electrode side
// ----------------------------------------
module cvt_far_model #(
	parameter int CONV_CYC = 5
) (
	// clock
	input wire logic clk,
	// converter handshake
	input wire logic conv_start,
	output logic conv_done,
	// rc clock source
	input wire logic rc_run,
	output logic rc_tick,
	// guard pins
	input wire logic a_o,
	input wire logic a_oe,
	input wire logic b_o,
	input wire logic b_oe,
	output logic a_pin,
	output logic b_pin
);
	int cnt = 0;
	// conversion runs a fixed count, then pulses done
	always_ff @(posedge clk) begin
		if (conv_start)
			cnt <= CONV_CYC;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	assign conv_done = (cnt == 1);
	// rc clock modelled at full rate while selected
	assign rc_tick = rc_run;
	// electrodes pulled low while not driven
	assign a_pin = a_oe ? a_o : 1'b0;
	assign b_pin = b_oe ? b_o : 1'b0;
endmodule : cvt_far_model
